// ===== verilog/spdif_serial_in.sv
// serial audio input port: frames bit clock, frame clock and data into words
module spdif_serial_in (
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    input  wire logic                      bit_clk,
    input  wire logic                      frame_clk,
    input  wire logic                      ser_data,
    input  wire spdif_in_pkg::frame_fmt_t  fmt_sel,
    input  wire spdif_in_pkg::word_width_t width_sel,
    output spdif_in_pkg::sample_t          sample,
    output logic                           sample_valid
);
    import spdif_in_pkg::*;

    // settled pin levels from the synchronisers
    logic        bclk_s;
    logic        fclk_s;
    logic        data_s;

    // previous levels, kept for edge detection
    logic        bclk_prev_q;
    logic        fclk_prev_q;

    // framing state: armed flag, slot position, captured count
    logic        started_q;
    logic [5:0]  bitpos_q;
    logic [5:0]  got_q;

    // word assembly
    logic [WORD_MAX-1:0] shift_q;
    logic        chan_right_q;
    logic        done_q;

    // one-step increment shared by the slot and bit counters
    function automatic logic [5:0] bump(input logic [5:0] v);
        bump = v + 6'h01;
    endfunction : bump

    // all three pins see the same synchroniser depth, so their relative timing is kept
    pin_sync u_sync_bclk (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pin     (bit_clk),
        .level   (bclk_s)
    );

    pin_sync u_sync_fclk (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pin     (frame_clk),
        .level   (fclk_s)
    );

    pin_sync u_sync_data (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pin     (ser_data),
        .level   (data_s)
    );

    // rising bit clock edge is the only capture instant
    wire         bclk_rise = bclk_s & ~bclk_prev_q;
    wire         fclk_edge = bclk_rise & (fclk_s != fclk_prev_q);
    wire [5:0]   wbits     = width_bits(width_sel);

    // msb delay per format; unknown codes fall back to I2S
    wire [5:0]   msb_delay = (fmt_sel == FMT_RIGHT) ? HALF_FRAME - wbits
                           : (fmt_sel == FMT_LEFT)  ? LEFT_DELAY
                           : I2S_DELAY;

    // channel from frame clock level: the justified formats invert the sense
    wire         is_right  = (fmt_sel == FMT_LEFT || fmt_sel == FMT_RIGHT)
                           ? ~fclk_s
                           : fclk_s;

    // bit position within the half frame; position 0 is the edge of the transition
    wire         started_q_or_edge = started_q | fclk_edge;
    wire         done_sel  = fclk_edge ? 1'b0 : done_q;
    wire [5:0]   got_base  = fclk_edge ? 6'h00 : got_q;
    wire [5:0]   got_next  = bump(got_base);
    wire [5:0]   pos_now   = fclk_edge ? 6'h00 : bump(bitpos_q);
    // a slot is taken only once armed, before the word is full and past the msb delay
    wire         take_bit  = bclk_rise && started_q_or_edge && !done_sel && pos_now >= msb_delay;
    wire         last_bit  = take_bit && (got_next == wbits);

    // edge trackers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bclk_prev_q <= 1'b0;
            fclk_prev_q <= 1'b0;
        end else begin
            bclk_prev_q <= bclk_s;
            if (bclk_rise) begin
                fclk_prev_q <= fclk_s;
            end
        end
    end

    // position and bit counters; first frame transition arms the port
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            started_q <= 1'b0;
            bitpos_q  <= 6'h00;
            got_q     <= 6'h00;
            done_q    <= 1'b0;
        end else if (bclk_rise) begin
            started_q <= started_q_or_edge;
            bitpos_q  <= pos_now;
            got_q     <= take_bit ? got_next : got_base;
            done_q    <= done_sel | last_bit;
        end
    end

    // shift register, msb first
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shift_q      <= '0;
            chan_right_q <= 1'b0;
        end else if (take_bit) begin
            shift_q      <= {shift_q[WORD_MAX-2:0], data_s};
            chan_right_q <= is_right;
        end
    end

    // finished word, left aligned on the 24-bit bus
    wire [4:0] pad = 5'(6'(WORD_MAX) - wbits);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sample       <= '0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= last_bit;
            if (last_bit) begin
                sample.right <= is_right;
                sample.data  <= WORD_MAX'({shift_q[WORD_MAX-2:0], data_s} << pad);
            end
        end
    end

    // a word strobe always follows the configured number of captured bits
    word_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid |-> $past(got_q) + 6'h01 == $past(wbits))
        else $error("word strobe before full width");
    // no capture before the msb slot
    msb_slot_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        take_bit |-> pos_now >= msb_delay)
        else $error("bit taken before msb delay");
    // one strobe per half frame
    one_word_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid |=> !sample_valid)
        else $error("double word strobe");

    // channel sense checks use the frame level seen at the last bit
    // i2s and its fallback code: low is left
    chan_i2s_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid && fmt_sel != FMT_LEFT && fmt_sel != FMT_RIGHT |-> sample.right == $past(fclk_s))
        else $error("i2s channel tag wrong");

    // justified formats: high is left
    chan_just_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid && (fmt_sel == FMT_LEFT || fmt_sel == FMT_RIGHT) |-> sample.right == !$past(fclk_s))
        else $error("justified channel tag wrong");

    // sixteen-bit words leave the low eight-bit pad at zero
    pad_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid && width_sel == WID_16 |-> sample.data[7:0] == 8'h00)
        else $error("16-bit word pad not zero");

    // twenty-bit words keep a four-bit pad
    pad_twenty_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid && width_sel == WID_20 |-> sample.data[3:0] == 4'h0)
        else $error("20-bit word pad not zero");

    // left-justified msb sits on the transition edge itself
    left_first_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        fclk_edge && fmt_sel == FMT_LEFT |-> take_bit)
        else $error("left-justified msb missed");

    // i2s never takes the transition slot
    i2s_skip_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        fclk_edge && fmt_sel == FMT_I2S |-> !take_bit)
        else $error("i2s bit taken on transition");

    // i2s msb is the slot right after the transition
    i2s_msb_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        bclk_rise && !fclk_edge && started_q && bitpos_q == 6'h00 && fmt_sel == FMT_I2S |-> take_bit)
        else $error("i2s msb slot missed");

    // right-justified never takes the transition slot
    rj_skip_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        fclk_edge && fmt_sel == FMT_RIGHT |-> !take_bit)
        else $error("right-justified bit taken on transition");

    // right-justified 20-bit msb lands twelve slots late
    rj_twenty_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        bclk_rise && !fclk_edge && started_q && bitpos_q == 6'h0B && fmt_sel == FMT_RIGHT
        && width_sel == WID_20 |-> take_bit && got_base == 6'h00)
        else $error("right-justified 20-bit msb slot missed");

    // right-justified 16-bit msb lands sixteen slots late
    rj_sixteen_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        bclk_rise && !fclk_edge && started_q && bitpos_q == 6'h0F && fmt_sel == FMT_RIGHT
        && width_sel == WID_16 |-> take_bit && got_base == 6'h00)
        else $error("right-justified 16-bit msb slot missed");

    // nothing is captured before the first transition
    arm_first_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !started_q && !fclk_edge |-> !take_bit)
        else $error("bit taken before arming");

    // a full word blocks capture until the next transition
    ignore_tail_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        done_q && !fclk_edge |-> !take_bit)
        else $error("bit taken after full word");

    // every transition reopens capture
    done_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        fclk_edge |=> !done_q)
        else $error("word lock not cleared");

    // the word only moves with its strobe
    hold_sample_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !sample_valid |-> $stable(sample))
        else $error("sample moved without strobe");
endmodule : spdif_serial_in

// ===== verilog/spdif_in_pkg.sv
// package: constants, types and behaviour list for the serial audio input stage
// Behaviour
// - three framing formats selectable: left-justified, I2S, right-justified.
// - word width selectable as 16, 18, 20 or 24 bits.
// - data and frame clock captured on rising bit clock edge.
// - right-justified: frame clock high is left, low is right.
// - right-justified: MSB 12 periods late for 20-bit, 16 for 16-bit.
// - with no format chosen the port runs I2S framing.
// - I2S: frame clock low is left, high is right.
// - I2S: MSB one bit clock after frame transition, then descending bits.
// - left-justified: frame clock high is left, low is right.
// - left-justified: MSB on first rising edge after transition.
package spdif_in_pkg;
    typedef enum logic [1:0] {
        FMT_I2S   = 2'h0,
        FMT_LEFT  = 2'h1,
        FMT_RIGHT = 2'h2
    } frame_fmt_t;

    typedef enum logic [1:0] {
        WID_16 = 2'h0,
        WID_18 = 2'h1,
        WID_20 = 2'h2,
        WID_24 = 2'h3
    } word_width_t;

    localparam int          WORD_MAX      = 24;
    localparam int          CNT_W         = 6;
    localparam logic [5:0]  HALF_FRAME    = 6'h20;
    localparam logic [5:0]  I2S_DELAY     = 6'h01;
    localparam logic [5:0]  LEFT_DELAY    = 6'h00;

    typedef struct packed {
        logic                  right;
        logic [WORD_MAX-1:0]   data;
    } sample_t;

    // width code to bit count
    function automatic logic [5:0] width_bits(input word_width_t w);
        case (w)
            WID_16:  width_bits = 6'h10;
            WID_18:  width_bits = 6'h12;
            WID_20:  width_bits = 6'h14;
            default: width_bits = 6'h18;
        endcase
    endfunction : width_bits
endpackage : spdif_in_pkg

// ===== verilog/pin_sync.sv
// three-flop pin synchroniser that reports a settled level
module pin_sync (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // level moves only when the second and third flops agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule : pin_sync

// ===== testbench/audio_src.sv
// upstream serial audio source model
module audio_src
    import spdif_in_pkg::*;
(
    input  wire logic clk_sys,
    output logic      bit_clk,
    output logic      frame_clk,
    output logic      ser_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // bit clock idles low outside frames
    initial begin
        bit_clk = 1'b0;
        frame_clk = 1'b0;
        ser_data = 1'b0;
    end
    // change on the low phase, sampled on the rising bit clock
    task automatic send_bit(input logic lvl, input logic d);
        bit_clk <= 1'b0;
        frame_clk <= lvl;
        ser_data <= d;
        repeat (4) @(negedge clk_sys);
        bit_clk <= 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : send_bit
    // idle slots carry the inverse of the last bit, never a stale copy
    task automatic send_frame(input frame_fmt_t f, input int w, input logic [23:0] l, input logic [23:0] r);
        int          dly;
        logic        lft;
        logic [23:0] wd;
        dly = (f == FMT_LEFT) ? 0 : (f == FMT_RIGHT) ? 32 - w : 1;
        lft = (f == FMT_LEFT || f == FMT_RIGHT);
        if (frame_clk == lft) begin
            repeat (2) send_bit(!lft, !ser_data);
        end
        for (int h = 0; h < 2; h++) begin
            wd = h ? r : l;
            for (int p = 0; p < 32; p++) begin
                send_bit(lft ^ h[0], (p >= dly && p < dly + w) ? wd[23 - p + dly] : !ser_data);
            end
        end
        bit_clk <= 1'b0;
    endtask : send_frame
endmodule : audio_src

// ===== testbench/testbench.sv
// self-checking bench for the serial audio input port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spdif_in_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        bit_clk, frame_clk, ser_data, sample_valid;
    frame_fmt_t  fmt_sel = FMT_I2S;
    word_width_t width_sel = WID_16;
    sample_t     sample;
    sample_t     got[$];
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;
    always #10 clk_sys = ~clk_sys;
    audio_src SRC (.clk_sys(clk_sys), .bit_clk(bit_clk), .frame_clk(frame_clk), .ser_data(ser_data));
    spdif_serial_in DUT (.clk_sys(clk_sys), .rstn(rstn), .bit_clk(bit_clk), .frame_clk(frame_clk),
        .ser_data(ser_data), .fmt_sel(fmt_sel), .width_sel(width_sel), .sample(sample),
        .sample_valid(sample_valid));
    // collect words; hang guard sized for about 39 frames
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (sample_valid === 1'b1) got.push_back(sample);
        if (cycles == 20000) begin
            errors = errors + 1;
            complete_run();
        end
    end
    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // one frame; expected words keep only the top width bits
    task automatic run_case(input frame_fmt_t f, input word_width_t w, input logic [23:0] l, input logic [23:0] r);
        int          n;
        logic [23:0] m;
        n = (w == WID_16) ? 16 : (w == WID_18) ? 18 : (w == WID_20) ? 20 : 24;
        m = ~(24'hFFFFFF >> n);
        @(negedge clk_sys);
        fmt_sel = f;
        width_sel = w;
        got.delete();
        SRC.send_frame(f, n, l, r);
        repeat (16) @(negedge clk_sys);
        check(25'(got.size()), 25'h2);
        if (got.size() == 2) begin
            check(got[0], {1'b0, l & m});
            check(got[1], {1'b1, r & m});
        end
    endtask : run_case
    task automatic test_i2s;
        for (int i = 0; i < 4; i++) run_case(FMT_I2S, word_width_t'(i), 24'hC6B5A9, 24'h394A56);
        run_case(frame_fmt_t'(2'h3), WID_24, 24'h9ABCDE, 24'h654321);
    endtask : test_i2s
    task automatic test_left;
        for (int i = 0; i < 4; i++) run_case(FMT_LEFT, word_width_t'(i), 24'hB3E1C5, 24'h4C1E3A);
    endtask : test_left
    task automatic test_right;
        for (int i = 0; i < 4; i++) run_case(FMT_RIGHT, word_width_t'(i), 24'h8F1E2D, 24'h71E1D3);
    endtask : test_right
    task automatic complete_run;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    // reset for 20 cycles, then every format
    initial begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        test_i2s();
        test_left();
        test_right();
        complete_run();
    end
endmodule : testbench
